// File: logic/pfx_addr_check.sv
`timescale 1ns/100ps
`default_nettype none
module pfx_addr_check
  import pfx_pkg::*;
(
  input  wire logic [PFX_ADDR_W-1:0] addr,
  input  wire logic                  is_instr,
  input  wire logic [31:0]           region_enables,
  input  wire logic [PFX_ADDR_W-1:0] zero_range_start,
  input  wire logic [PFX_ADDR_W-1:0] zero_range_end,
  input  wire logic                  zero_return_enable,
  output logic                       region_ok,
  output logic                       in_zero
);
  logic [4:0] bit_sel;

  assign bit_sel   = {is_instr, addr[PFX_ADDR_W-1:PFX_REGION_LSB]};
  assign region_ok = region_enables[bit_sel];
  // bounds compared on whole lines only
  assign in_zero   = zero_return_enable
                     && addr[PFX_ADDR_W-1:PFX_OFS_W] >= zero_range_start[PFX_ADDR_W-1:PFX_OFS_W]
                     && addr[PFX_ADDR_W-1:PFX_OFS_W] <= zero_range_end[PFX_ADDR_W-1:PFX_OFS_W];
endmodule
`default_nettype wire

// File: logic/pfx_line_prefetcher.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - With no miss outstanding, fetch the line after the last request, per port.
// - Each port prefetches only while its own enable bit is set.
// - Lines are 64 bytes; addresses and range bounds compare per line.
// - Enabled with L1 off, act as an eight-line single-way cache.
// - With zero-return on, lines inside the zero range return zeros, no fetch.
// - Invalidate bit written 1 then 0 with both enables set clears all lines.
// - Core reset marks every line invalid.
// - An L1 line invalidation also drops the same line here.
// - Regions with a cleared selection bit are not prefetched; set bits allow it.
// - Bits 31:16 govern instruction prefetch, bits 15:0 data prefetch.
// - Bit n and n+16 cover the 256 MB region with address bits 31:28 = n.
// - All selection bits are set after reset.
module pfx_line_prefetcher
  import pfx_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [11:0]              paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     l1_cache_on,
  input  wire logic                     i_req_valid,
  input  wire logic [PFX_ADDR_W-1:0]    i_req_addr,
  output logic                          i_req_ready,
  output logic                          i_resp_valid,
  input  wire logic                     d_req_valid,
  input  wire logic [PFX_ADDR_W-1:0]    d_req_addr,
  output logic                          d_req_ready,
  output logic                          d_resp_valid,
  output logic      [PFX_LINE_BITS-1:0] resp_data,
  output logic                          mem_req_valid,
  output logic      [PFX_ADDR_W-1:0]    mem_req_addr,
  input  wire logic                     mem_req_ready,
  input  wire logic                     mem_resp_valid,
  input  wire logic [PFX_LINE_BITS-1:0] mem_resp_data,
  input  wire logic                     l1_inval_valid,
  input  wire logic [PFX_ADDR_W-1:0]    l1_inval_addr
);
  pfx_store_if sif ();

  pfx_state_t                 state, next_state;
  logic [PFX_CTL_W-1:0]       core_system_control, next_core_system_control;
  logic [31:0]                prefetch_region_enables, next_prefetch_region_enables;
  logic [PFX_ADDR_W-1:0]      zero_range_start, next_zero_range_start;
  logic [PFX_ADDR_W-1:0]      zero_range_end, next_zero_range_end;
  logic [31:0]                next_prdata;
  logic [PFX_ADDR_W-1:0]      cur_addr, next_cur_addr;
  logic                       cur_instr, next_cur_instr;
  logic                       cur_pf, next_cur_pf;
  logic [1:0]                 pf_pend, next_pf_pend;
  logic [PFX_ADDR_W-1:0]      pf_addr [2];
  logic [PFX_ADDR_W-1:0]      next_pf_addr [2];
  logic                       next_i_resp, next_d_resp;
  logic [PFX_LINE_BITS-1:0]   next_resp_data;
  logic                       sel_valid, sel_instr, region_ok, in_zero, lk_instr;
  logic [PFX_ADDR_W-1:0]      sel_addr, follow_addr;
  logic                       port_en_lk, wr_en, rd_setup, mapped;
  logic                       data_side_prefetch_enable, instr_side_prefetch_enable;

  assign data_side_prefetch_enable  = core_system_control[PFX_BIT_DEN];
  assign instr_side_prefetch_enable = core_system_control[PFX_BIT_IEN];

  // ---------------- APB slave: zero wait states ----------------
  assign pready   = 1'b1;
  assign mapped   = paddr inside {PFX_OFS_SYSCTL, PFX_OFS_REGION, PFX_OFS_ZSTART,
                                  PFX_OFS_ZEND, PFX_OFS_STATUS};
  assign pslverr  = psel && penable && !mapped;
  assign wr_en    = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb
  begin
    next_core_system_control     = core_system_control;
    next_prefetch_region_enables = prefetch_region_enables;
    next_zero_range_start        = zero_range_start;
    next_zero_range_end          = zero_range_end;
    next_prdata                  = prdata;
    if (wr_en)
      unique case (paddr)
        PFX_OFS_SYSCTL: next_core_system_control     = pwdata[PFX_CTL_W-1:0];
        PFX_OFS_REGION: next_prefetch_region_enables = pwdata;
        PFX_OFS_ZSTART: next_zero_range_start        = pwdata;
        PFX_OFS_ZEND:   next_zero_range_end          = pwdata;
        default:        next_prdata                  = prdata;
      endcase
    // read data captured in setup so it is a flop output during the access phase
    if (rd_setup)
      unique case (paddr)
        PFX_OFS_SYSCTL: next_prdata = {28'h0000000, core_system_control};
        PFX_OFS_REGION: next_prdata = prefetch_region_enables;
        PFX_OFS_ZSTART: next_prdata = zero_range_start;
        PFX_OFS_ZEND:   next_prdata = zero_range_end;
        PFX_OFS_STATUS: next_prdata = {21'h00000, pf_pend, state != PFX_IDLE, sif.valid_map};
        default:        next_prdata = 32'h00000000;
      endcase
  end

  // whole-buffer clear on the falling edge of the invalidate bit, written with both enables set
  assign sif.inval_all = wr_en && paddr == PFX_OFS_SYSCTL && core_system_control[PFX_BIT_INV]
                         && !pwdata[PFX_BIT_INV] && pwdata[PFX_BIT_DEN] && pwdata[PFX_BIT_IEN];
  assign sif.inval_line = l1_inval_valid;
  assign sif.inval_addr = l1_inval_addr;

  // ---------------- request engine ----------------
  // data port wins a tie; the instruction port waits while a data request is valid or the engine is not idle
  assign sel_valid   = d_req_valid || i_req_valid;
  assign sel_instr   = !d_req_valid;
  assign sel_addr    = d_req_valid ? d_req_addr : i_req_addr;
  assign d_req_ready = state == PFX_IDLE;
  assign i_req_ready = state == PFX_IDLE && !d_req_valid;

  always_comb
  begin
    sif.lk_addr = cur_addr;
    lk_instr    = cur_instr;
    if (state == PFX_IDLE)
    begin
      if (sel_valid)
      begin
        sif.lk_addr = sel_addr;
        lk_instr    = sel_instr;
      end
      else
      begin
        sif.lk_addr = pf_pend[0] ? pf_addr[0] : pf_addr[1];
        lk_instr    = !pf_pend[0];
      end
    end
  end

  pfx_addr_check u_check (
    .addr               (sif.lk_addr),
    .is_instr           (lk_instr),
    .region_enables     (prefetch_region_enables),
    .zero_range_start   (zero_range_start),
    .zero_range_end     (zero_range_end),
    .zero_return_enable (core_system_control[PFX_BIT_ZEN]),
    .region_ok          (region_ok),
    .in_zero            (in_zero)
  );

  pfx_line_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  assign port_en_lk    = lk_instr ? instr_side_prefetch_enable : data_side_prefetch_enable;
  assign follow_addr   = {sif.lk_addr[PFX_ADDR_W-1:PFX_OFS_W] + 26'd1, 6'h00};
  assign mem_req_valid = state == PFX_MEM_REQ;
  assign mem_req_addr  = {cur_addr[PFX_ADDR_W-1:PFX_OFS_W], 6'h00};
  assign sif.fill_addr = cur_addr;
  assign sif.fill_data = mem_resp_data;
  // demand misses are kept only in tiny-cache mode; prefetched lines always
  assign sif.fill_en   = state == PFX_MEM_WAIT && mem_resp_valid
                         && (cur_pf || (!l1_cache_on && port_en_lk));

  always_comb
  begin
    next_state     = state;
    next_cur_addr  = cur_addr;
    next_cur_instr = cur_instr;
    next_cur_pf    = cur_pf;
    next_pf_pend   = pf_pend;
    next_pf_addr   = pf_addr;
    next_i_resp    = 1'b0;
    next_d_resp    = 1'b0;
    next_resp_data = resp_data;
    unique case (state)
      PFX_IDLE:
        if (sel_valid)
        begin
          next_cur_addr  = sel_addr;
          next_cur_instr = sel_instr;
          next_cur_pf    = 1'b0;
          if (in_zero || sif.lk_hit)
          begin
            next_i_resp    = sel_instr;
            next_d_resp    = !sel_instr;
            next_resp_data = in_zero ? '0 : sif.lk_data;
            if (port_en_lk && region_ok)
            begin
              next_pf_pend[sel_instr] = 1'b1;
              next_pf_addr[sel_instr] = follow_addr;
            end
          end
          else
            next_state = PFX_MEM_REQ;
        end
        else if (pf_pend != 2'b00)
        begin
          // background fetch only when no demand is waiting
          next_pf_pend[lk_instr] = 1'b0;
          next_cur_addr          = sif.lk_addr;
          next_cur_instr         = lk_instr;
          next_cur_pf            = 1'b1;
          if (port_en_lk && region_ok && !in_zero && !sif.lk_hit)
            next_state = PFX_MEM_REQ;
        end
      PFX_MEM_REQ:
        if (mem_req_ready)
          next_state = PFX_MEM_WAIT;
      PFX_MEM_WAIT:
        if (mem_resp_valid)
        begin
          next_state = PFX_IDLE;
          if (!cur_pf)
          begin
            next_i_resp    = cur_instr;
            next_d_resp    = !cur_instr;
            next_resp_data = mem_resp_data;
            if (port_en_lk && region_ok)
            begin
              next_pf_pend[cur_instr] = 1'b1;
              next_pf_addr[cur_instr] = follow_addr;
            end
          end
        end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_system_control     <= PFX_RST_SYSCTL;
      prefetch_region_enables <= PFX_RST_REGION;
      zero_range_start        <= PFX_RST_ZRANGE;
      zero_range_end          <= PFX_RST_ZRANGE;
      prdata                  <= 32'h00000000;
      state                   <= PFX_IDLE;
      cur_addr                <= '0;
      cur_instr               <= 1'b0;
      cur_pf                  <= 1'b0;
      pf_pend                 <= 2'b00;
      pf_addr                 <= '{default: '0};
      i_resp_valid            <= 1'b0;
      d_resp_valid            <= 1'b0;
      resp_data               <= '0;
    end
    else
    begin
      core_system_control     <= next_core_system_control;
      prefetch_region_enables <= next_prefetch_region_enables;
      zero_range_start        <= next_zero_range_start;
      zero_range_end          <= next_zero_range_end;
      prdata                  <= next_prdata;
      state                   <= next_state;
      cur_addr                <= next_cur_addr;
      cur_instr               <= next_cur_instr;
      cur_pf                  <= next_cur_pf;
      pf_pend                 <= next_pf_pend;
      pf_addr                 <= next_pf_addr;
      i_resp_valid            <= next_i_resp;
      d_resp_valid            <= next_d_resp;
      resp_data               <= next_resp_data;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_demand_taken;
    state == PFX_IDLE && sel_valid;
  endsequence

  sequence s_served_locally;
    (d_resp_valid || i_resp_valid) && !mem_req_valid;
  endsequence

  AST_PF_ONLY_WHEN_QUIET: assert property (
    $rose(mem_req_valid) && cur_pf |-> $past(!d_req_valid && !i_req_valid && state == PFX_IDLE))
    else $error("prefetch issued while a demand was waiting");

  AST_PF_NEEDS_ENABLE: assert property (
    $rose(pf_pend[0]) |-> $past(data_side_prefetch_enable))
    else $error("data prefetch queued with data prefetch disabled");

  AST_PF_NEXT_LINE: assert property (
    $rose(pf_pend[1]) |-> pf_addr[1][5:0] == 6'h00
      && pf_addr[1][31:6] == $past(sif.lk_addr[31:6]) + 26'd1)
    else $error("prefetch address is not the following 64-byte line");

  AST_HIT_NO_MEMORY: assert property (
    s_demand_taken ##0 (sif.lk_hit && !in_zero) |=> s_served_locally ##0 state == PFX_IDLE)
    else $error("buffer hit went to external memory");

  AST_ZERO_RETURN: assert property (
    s_demand_taken ##0 in_zero |=> (resp_data == '0) and s_served_locally)
    else $error("zero range line not answered with zeros");

  AST_INVAL_ALL: assert property (
    sif.inval_all |=> sif.valid_map == 8'h00)
    else $error("lines still valid after whole invalidate");

  AST_REGION_INSTR: assert property (
    $rose(pf_pend[1]) |-> $past(prefetch_region_enables[{1'b1, sif.lk_addr[31:28]}]))
    else $error("instruction prefetch queued from a disabled region");

  AST_REGION_DATA: assert property (
    $rose(pf_pend[0]) |-> $past(prefetch_region_enables[{1'b0, sif.lk_addr[31:28]}]))
    else $error("data prefetch queued from a disabled region");

  AST_NO_PF_DISABLED: assert property (
    s_demand_taken ##0 !region_ok |=> pf_pend == $past(pf_pend))
    else $error("demand in disabled region queued a prefetch");

endmodule
`default_nettype wire

// File: logic/pfx_line_store.sv
`timescale 1ns/100ps
`default_nettype none
module pfx_line_store
  import pfx_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  pfx_store_if.store sif
);
  logic [PFX_ENTRIES-1:0]   valid;
  logic [PFX_ENTRIES-1:0]   next_valid;
  logic [PFX_TAG_W-1:0]     tag      [PFX_ENTRIES];
  logic [PFX_TAG_W-1:0]     next_tag [PFX_ENTRIES];
  logic [PFX_LINE_BITS-1:0] data     [PFX_ENTRIES];
  logic [PFX_LINE_BITS-1:0] next_data[PFX_ENTRIES];
  logic [PFX_IDX_W-1:0]     lk_idx;
  logic [PFX_IDX_W-1:0]     fill_idx;
  logic [PFX_IDX_W-1:0]     inv_idx;

  // single way: the line index picks the one slot a line may live in
  assign lk_idx        = sif.lk_addr[PFX_TAG_LSB-1:PFX_OFS_W];
  assign fill_idx      = sif.fill_addr[PFX_TAG_LSB-1:PFX_OFS_W];
  assign inv_idx       = sif.inval_addr[PFX_TAG_LSB-1:PFX_OFS_W];
  assign sif.lk_hit    = valid[lk_idx] && (tag[lk_idx] == sif.lk_addr[PFX_ADDR_W-1:PFX_TAG_LSB]);
  assign sif.lk_data   = data[lk_idx];
  assign sif.valid_map = valid;

  for (genvar g = 0; g < PFX_ENTRIES; g++)
  begin : g_entry
    always_comb
    begin
      next_valid[g] = valid[g];
      next_tag[g]   = tag[g];
      next_data[g]  = data[g];
      if (sif.fill_en && fill_idx == PFX_IDX_W'(g))
      begin
        next_valid[g] = 1'b1;
        next_tag[g]   = sif.fill_addr[PFX_ADDR_W-1:PFX_TAG_LSB];
        next_data[g]  = sif.fill_data;
      end
      // invalidation applied last so a stale fill in the same cycle cannot survive it
      if (sif.inval_line && inv_idx == PFX_IDX_W'(g)
          && next_tag[g] == sif.inval_addr[PFX_ADDR_W-1:PFX_TAG_LSB])
        next_valid[g] = 1'b0;
      if (sif.inval_all)
        next_valid[g] = 1'b0;

    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        valid[g] <= 1'b0;
        tag[g]   <= '0;
        data[g]  <= '0;
      end
      else
      begin
        valid[g] <= next_valid[g];
        tag[g]   <= next_tag[g];
        data[g]  <= next_data[g];
      end
    end
  end

  // checked here where the tags are visible: a matching copy must be gone next cycle
  AST_L1_LINE_INVAL: assert property (
    @(posedge pclk) disable iff (!presetn)
    sif.inval_line |=> !(valid[$past(inv_idx)]
      && tag[$past(inv_idx)] == $past(sif.inval_addr[PFX_ADDR_W-1:PFX_TAG_LSB])))
    else $error("line kept after L1 invalidated it");
endmodule
`default_nettype wire

// File: logic/pfx_pkg.sv
`default_nettype none
package pfx_pkg;
  localparam int          PFX_ADDR_W     = 32;
  localparam int          PFX_LINE_BYTES = 64;
  localparam int          PFX_OFS_W      = 6;
  localparam int          PFX_LINE_BITS  = PFX_LINE_BYTES * 8;
  localparam int          PFX_ENTRIES    = 8;
  localparam int          PFX_IDX_W      = 3;
  localparam int          PFX_TAG_LSB    = PFX_OFS_W + PFX_IDX_W;
  localparam int          PFX_TAG_W      = PFX_ADDR_W - PFX_TAG_LSB;
  localparam int          PFX_REGION_LSB = 28;
  localparam int          PFX_INSTR_HALF = 16;
  localparam logic [11:0] PFX_OFS_SYSCTL = 12'h000;
  localparam logic [11:0] PFX_OFS_REGION = 12'h004;
  localparam logic [11:0] PFX_OFS_ZSTART = 12'h008;
  localparam logic [11:0] PFX_OFS_ZEND   = 12'h00C;
  localparam logic [11:0] PFX_OFS_STATUS = 12'h010;
  localparam int          PFX_BIT_DEN    = 0;
  localparam int          PFX_BIT_IEN    = 1;
  localparam int          PFX_BIT_ZEN    = 2;
  localparam int          PFX_BIT_INV    = 3;
  localparam int          PFX_CTL_W      = 4;
  localparam int          PFX_ST_BUSY    = 8;
  localparam int          PFX_ST_PEND    = 9;
  localparam logic [3:0]  PFX_RST_SYSCTL = 4'h0;
  localparam logic [31:0] PFX_RST_REGION = 32'hFFFFFFFF;
  localparam logic [31:0] PFX_RST_ZRANGE = 32'h00000000;
  typedef enum logic [1:0] {PFX_IDLE, PFX_MEM_REQ, PFX_MEM_WAIT} pfx_state_t;
endpackage
`default_nettype wire

// File: logic/pfx_store_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pfx_store_if;
  import pfx_pkg::*;
  logic [PFX_ADDR_W-1:0]    lk_addr;
  logic                     lk_hit;
  logic [PFX_LINE_BITS-1:0] lk_data;
  logic                     fill_en;
  logic [PFX_ADDR_W-1:0]    fill_addr;
  logic [PFX_LINE_BITS-1:0] fill_data;
  logic                     inval_all;
  logic                     inval_line;
  logic [PFX_ADDR_W-1:0]    inval_addr;
  logic [PFX_ENTRIES-1:0]   valid_map;
  modport main (output lk_addr, fill_en, fill_addr, fill_data, inval_all, inval_line,
                inval_addr, input lk_hit, lk_data, valid_map);
  modport store (input lk_addr, fill_en, fill_addr, fill_data, inval_all, inval_line,
                 inval_addr, output lk_hit, lk_data, valid_map);
endinterface
`default_nettype wire

// File: sim/pfx_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfx_mem_model
  import pfx_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     slow,
  input  wire logic                     mem_req_valid,
  input  wire logic [PFX_ADDR_W-1:0]    mem_req_addr,
  output logic                          mem_req_ready,
  output var logic                      mem_resp_valid,
  output var logic  [PFX_LINE_BITS-1:0] mem_resp_data
);
  logic [PFX_ADDR_W-1:0] addr;
  logic [3:0]            cnt;
  logic [3:0]            wt;
  logic                  busy;
  // slow mode stalls the request three cycles and answers late
  assign mem_req_ready = !busy && (!slow || wt == 4'h3);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy           <= 1'b0;
      cnt            <= 4'h0;
      wt             <= 4'h0;
      addr           <= 32'h0;
      mem_resp_valid <= 1'b0;
      mem_resp_data  <= '0;
    end
    else
    begin
      mem_resp_valid <= 1'b0;
      // data outside a beat keeps changing so a late sample cannot pass
      mem_resp_data  <= ~mem_resp_data;
      wt             <= (mem_req_valid && !busy && wt != 4'h3) ? wt + 4'h1 : 4'h0;
      if (busy)
      begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1)
        begin
          busy           <= 1'b0;
          mem_resp_valid <= 1'b1;
          mem_resp_data  <= {16{addr}};
        end
      end
      else if (mem_req_valid && mem_req_ready)
      begin
        busy <= 1'b1;
        addr <= mem_req_addr;
        cnt  <= slow ? 4'h8 : 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import pfx_pkg::*;
;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                     l1_cache_on, slow, l1_inval_valid;
  logic                     i_req_valid, i_req_ready, i_resp_valid;
  logic                     d_req_valid, d_req_ready, d_resp_valid;
  logic                     mem_req_valid, mem_req_ready, mem_resp_valid;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata;
  logic [PFX_ADDR_W-1:0]    i_req_addr, d_req_addr, mem_req_addr, l1_inval_addr;
  logic [PFX_LINE_BITS-1:0] resp_data, mem_resp_data;
  int                       n_mismatch, check_count, cyc;
  logic [31:0]              mq[$];

  pfx_line_prefetcher DUT (
    .pclk           (pclk),
    .presetn        (presetn),
    .paddr          (paddr),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .l1_cache_on    (l1_cache_on),
    .i_req_valid    (i_req_valid),
    .i_req_addr     (i_req_addr),
    .i_req_ready    (i_req_ready),
    .i_resp_valid   (i_resp_valid),
    .d_req_valid    (d_req_valid),
    .d_req_addr     (d_req_addr),
    .d_req_ready    (d_req_ready),
    .d_resp_valid   (d_resp_valid),
    .resp_data      (resp_data),
    .mem_req_valid  (mem_req_valid),
    .mem_req_addr   (mem_req_addr),
    .mem_req_ready  (mem_req_ready),
    .mem_resp_valid (mem_resp_valid),
    .mem_resp_data  (mem_resp_data),
    .l1_inval_valid (l1_inval_valid),
    .l1_inval_addr  (l1_inval_addr)
  );
  pfx_mem_model mem (
    .pclk           (pclk),
    .presetn        (presetn),
    .slow           (slow),
    .mem_req_valid  (mem_req_valid),
    .mem_req_addr   (mem_req_addr),
    .mem_req_ready  (mem_req_ready),
    .mem_resp_valid (mem_resp_valid),
    .mem_resp_data  (mem_resp_data)
  );

  always #4 pclk = ~pclk;

  always @(posedge pclk)
  begin
    if (mem_req_valid === 1'b1 && mem_req_ready)
      mq.push_back(mem_req_addr);
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      test_done;
    end
  end

  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [511:0] e, input logic [511:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    logic rdy;
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // the answer is taken at the rising edge at which pready is seen high
    do
    begin
      @(posedge pclk);
      rdy = pready;
      rd  = prdata;
      er  = pslverr;
    end
    while (rdy !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle cycle so a following call never raises psel in the same step
    @(posedge pclk);
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("register %0h", a), x, r);
    chk("pslverr", 0, e);
  endtask

  // waits out background fetches so each check sees a quiet engine
  task automatic idle;
    logic [31:0] r;
    logic        e;
    repeat (40)
    begin
      apb(1'b0, PFX_OFS_STATUS, 32'h0, r, e);
      if (r[10:8] === 3'h0)
        break;
    end
  endtask

  task automatic req(input logic ii, input logic [31:0] a, input logic [511:0] x, input int nm);
    int n0;
    n0 = mq.size();
    if (ii)
    begin
      i_req_valid <= 1'b1;
      i_req_addr  <= a;
    end
    else
    begin
      d_req_valid <= 1'b1;
      d_req_addr  <= a;
    end
    do @(posedge pclk); while ((ii ? i_req_ready : d_req_ready) !== 1'b1);
    i_req_valid <= 1'b0;
    d_req_valid <= 1'b0;
    do @(posedge pclk); while ((ii ? i_resp_valid : d_resp_valid) !== 1'b1);
    chk("resp_data", x, resp_data);
    chk("memory requests", 512'(nm), 512'(mq.size() - n0));
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rreg(PFX_OFS_REGION, PFX_RST_REGION);
    rreg(PFX_OFS_SYSCTL, 32'h0);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("pslverr", 1, e);
    chk("unmapped read", 0, r);
    wreg(PFX_OFS_REGION, 32'h5A5AA5A5);
    rreg(PFX_OFS_REGION, 32'h5A5AA5A5);
    wreg(PFX_OFS_REGION, PFX_RST_REGION);
  endtask

  task automatic t_tiny;
    wreg(PFX_OFS_SYSCTL, 32'h3);
    req(1'b0, 32'h1000, {16{32'h1000}}, 1);
    idle;
    chk("prefetch address", 32'h1040, mq[$]);
    req(1'b1, 32'h2080, {16{32'h2080}}, 1);
    idle;
    chk("prefetch address", 32'h20C0, mq[$]);
    req(1'b0, 32'h1010, {16{32'h1000}}, 0);
    idle;
    rreg(PFX_OFS_STATUS, 32'h0F);
  endtask

  task automatic t_inval;
    l1_inval_valid <= 1'b1;
    l1_inval_addr  <= 32'h1040;
    @(posedge pclk);
    l1_inval_valid <= 1'b0;
    @(posedge pclk);
    rreg(PFX_OFS_STATUS, 32'h0D);
    wreg(PFX_OFS_SYSCTL, 32'hB);
    wreg(PFX_OFS_SYSCTL, 32'h3);
    rreg(PFX_OFS_STATUS, 32'h0);
    req(1'b0, 32'h1000, {16{32'h1000}}, 1);
    idle;
  endtask

  task automatic t_zero;
    slow <= 1'b1;
    wreg(PFX_OFS_REGION, 32'hFFFFFFF7);
    wreg(PFX_OFS_ZSTART, 32'h30000000);
    wreg(PFX_OFS_ZEND, 32'h300000FF);
    rreg(PFX_OFS_ZEND, 32'h300000FF);
    wreg(PFX_OFS_SYSCTL, 32'h7);
    req(1'b0, 32'h30000080, '0, 0);
    req(1'b0, 32'h30000100, {16{32'h30000100}}, 1);
    idle;
    chk("prefetch address", 32'h30000100, mq[$]);
    req(1'b1, 32'h30000200, {16{32'h30000200}}, 1);
    idle;
    chk("prefetch address", 32'h30000240, mq[$]);
    wreg(PFX_OFS_REGION, 32'hFFFF7FFF);
    req(1'b0, 32'hF0000000, {16{32'hF0000000}}, 1);
    idle;
    chk("prefetch address", 32'hF0000000, mq[$]);
    wreg(PFX_OFS_SYSCTL, 32'h1);
    req(1'b1, 32'h40000000, {16{32'h40000000}}, 1);
    idle;
    chk("prefetch address", 32'h40000000, mq[$]);
    // with L1 on, demand misses are not kept but prefetched lines are
    l1_cache_on <= 1'b1;
    req(1'b0, 32'h50000000, {16{32'h50000000}}, 1);
    idle;
    chk("prefetch address", 32'h50000040, mq[$]);
    req(1'b0, 32'h50000000, {16{32'h50000000}}, 1);
    req(1'b0, 32'h50000040, {16{32'h50000040}}, 0);
    idle;
    l1_cache_on <= 1'b0;
  endtask

  task automatic t_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rreg(PFX_OFS_STATUS, 32'h0);
    rreg(PFX_OFS_REGION, PFX_RST_REGION);
    rreg(PFX_OFS_SYSCTL, 32'h0);
  endtask

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, slow, l1_inval_valid} = '0;
    {l1_cache_on, i_req_valid, d_req_valid, paddr, pwdata} = '0;
    {i_req_addr, d_req_addr, l1_inval_addr} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_tiny;
    t_inval;
    t_zero;
    t_reset;
    test_done;
  end
endmodule
`default_nettype wire
